// *** common/trap_status_consts.vh ***
`ifndef TRAP_STATUS_CONSTS_VH
`define TRAP_STATUS_CONSTS_VH

// apb byte addresses
`define ADDR_STATUS_WORD 12'h000
`define ADDR_CORE_CONTROL 12'h004
`define ADDR_TRAP_CONTROL 12'h008
`define ADDR_LEVEL_VIEW 12'h00C

// status word fields
`define SW_LEVEL_HI 7
`define SW_LEVEL_LO 5
`define SW_SAT_A 13
`define SW_SAT_B 12
`define SW_SAT_EITHER 10

// core control fields
`define CC_LEVEL_HIGH 3

// trap and nesting control fields
`define TC_NESTING_OFF 15
`define TC_OVF_A 14
`define TC_OVF_B 13
`define TC_CAT_A 12
`define TC_CAT_B 11
`define TC_OVF_A_EN 10
`define TC_OVF_B_EN 9
`define TC_CAT_EN 8
`define TC_BAD_SHIFT 7
`define TC_DIV_ZERO 6
`define TC_DMA_FAULT 5
`define TC_MATH 4
`define TC_ADDRESS 3
`define TC_STACK 2
`define TC_OSC_FAIL 1

// writable nesting_off and enable bits of the trap control word
`define TC_EN_MASK 16'h8700

`define RESET_WORD 16'h0000
`define LEVEL_TOP_USER 4'h7

`endif

// *** core/cpu_priority_and_trap_status.v ***
// Functional notes
// [RQ1] status word bits 7:5 hold level 0..7 binary; 111 blocks user interrupts
// [RQ2] effective level is high bit above the three low bits, adding eight
// [RQ3] high level bit set blocks every user interrupt source
// [RQ4] nesting_off set makes the three low level bits read-only to software
// [RQ5] core control bit 3 reads one exactly when the level exceeds seven
// [RQ6] saturation flags and high level bit are clear-only; writing one does nothing
// [RQ7] nesting_off prevents nesting; clear lets higher priority preempt a handler
// [RQ8] bits 14/13 flag accumulator A/B overflow traps, else zero
// [RQ9] bits 12/11 flag catastrophic overflow traps of A/B, else zero
// [RQ10] overflow traps of A/B raised only while enables 10/9 are one
// [RQ11] catastrophic overflow trap raised only while enable bit 8 is one
// [RQ12] bit 7 flags a math trap caused by an invalid accumulator shift
// [RQ13] bit 6 flags a math trap caused by division by zero
// [RQ14] bit 5 flags a dma controller error trap
// [RQ15] bit 4 flags any math error trap regardless of cause
// [RQ16] bit 3 flags an address error trap
// [RQ17] bit 2 flags a stack error trap
// [RQ18] bit 1 flags an oscillator failure trap
// [RQ19] bit 0 unimplemented: reads zero, writes ignored
// [RQ20] level masks sources not above it; software writes only low bits
// [RQ21] trap flags stay set until cleared; all flags and enables reset zero
`timescale 1ns/1ps
`include "trap_status_consts.vh"

module cpu_priority_and_trap_status (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // core side events, one-cycle pulses
    input wire acc_a_overflow_event,
    input wire acc_b_overflow_event,
    input wire acc_a_catastrophic_event,
    input wire acc_b_catastrophic_event,
    input wire bad_shift_event,
    input wire divide_zero_event,
    input wire dma_fault_event,
    input wire address_trap_event,
    input wire stack_trap_event,
    input wire osc_fail_trap_event,
    input wire acc_a_saturate_event,
    input wire acc_b_saturate_event,
    // core writes a new level on exception entry or return
    input wire level_load,
    input wire [3:0] level_load_value,
    // priority of the highest pending user source
    input wire [2:0] pending_priority,
    input wire pending_valid,
    input wire handler_active,
    output reg [3:0] cpu_level,
    output reg user_irq_blocked,
    output reg irq_take,
    output reg math_trap_raise,
    output reg acc_trap_raise,
    output reg nesting_off
);

    reg [2:0] level_low_q;
    reg level_high_q;
    reg sat_a_q;
    reg sat_b_q;
    reg [15:0] trap_ctl_q;

    wire acc_write;
    wire wr_status;
    wire wr_core;
    wire wr_trap;
    wire [15:0] wdata;
    wire ovf_a_trap;
    wire ovf_b_trap;
    wire cat_a_trap;
    wire cat_b_trap;
    wire math_any;
    wire [15:0] status_word;
    wire [15:0] core_word;
    wire [3:0] level_d;
    wire [15:0] trap_set;
    wire [15:0] trap_keep;

    function addr_hit;
        input [11:0] a;
        input [11:0] ref_addr;
        begin
            addr_hit = (a == ref_addr);
        end
    endfunction

    // only the low half carries register data; both low lanes must be strobed
    assign acc_write = psel && penable && pwrite && pready && (pstrb[1:0] == 2'h3);
    assign wr_status = acc_write && addr_hit(paddr, `ADDR_STATUS_WORD);
    assign wr_core = acc_write && addr_hit(paddr, `ADDR_CORE_CONTROL);
    assign wr_trap = acc_write && addr_hit(paddr, `ADDR_TRAP_CONTROL);
    assign wdata = pwdata[15:0];

    assign ovf_a_trap = acc_a_overflow_event && trap_ctl_q[`TC_OVF_A_EN]; // RQ10
    assign ovf_b_trap = acc_b_overflow_event && trap_ctl_q[`TC_OVF_B_EN]; // RQ10
    assign cat_a_trap = acc_a_catastrophic_event && trap_ctl_q[`TC_CAT_EN]; // RQ11
    assign cat_b_trap = acc_b_catastrophic_event && trap_ctl_q[`TC_CAT_EN]; // RQ11
    assign math_any = bad_shift_event || divide_zero_event || ovf_a_trap || ovf_b_trap
        || cat_a_trap || cat_b_trap; // RQ15

    // hardware set positions
    assign trap_set = {1'b0, ovf_a_trap, ovf_b_trap, cat_a_trap, cat_b_trap, // RQ8 RQ9
        3'h0, bad_shift_event, divide_zero_event, dma_fault_event, // RQ12 RQ13 RQ14
        math_any, address_trap_event, stack_trap_event, osc_fail_trap_event, // RQ16 RQ17 RQ18
        1'b0}; // RQ19

    // flags are sticky; software writing zero clears, set wins over clear
    assign trap_keep = wr_trap ? ((trap_ctl_q & wdata & ~`TC_EN_MASK)
        | (wdata & `TC_EN_MASK)) : trap_ctl_q; // RQ21

    assign level_d = {level_high_q, level_low_q}; // RQ2

    assign status_word = {2'h0, sat_a_q, sat_b_q, 1'b0, sat_a_q | sat_b_q, 2'h0,
        level_low_q, 5'h00}; // RQ1
    assign core_word = {12'h000, level_high_q, 3'h0}; // RQ5

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_low_q <= 3'h0;
            level_high_q <= 1'b0;
            sat_a_q <= 1'b0;
            sat_b_q <= 1'b0;
            trap_ctl_q <= `RESET_WORD; // RQ21
        end else begin
            trap_ctl_q <= (trap_keep | trap_set) & 16'hFFFE; // RQ19
            // saturation flags: clear-only by software, event wins
            sat_a_q <= acc_a_saturate_event
                || (sat_a_q && !(wr_status && !wdata[`SW_SAT_A])); // RQ6
            sat_b_q <= acc_b_saturate_event
                || (sat_b_q && !(wr_status && !wdata[`SW_SAT_B])); // RQ6
            if (level_load) begin
                // core load replaces both level fields with level_load_value, raising or lowering the level
                level_low_q <= level_load_value[2:0];
                level_high_q <= level_load_value[3];
            end else begin
                if (wr_status && !trap_ctl_q[`TC_NESTING_OFF]) begin
                    level_low_q <= wdata[`SW_LEVEL_HI:`SW_LEVEL_LO]; // RQ4 RQ20
                end
                if (wr_core && !wdata[`CC_LEVEL_HIGH]) begin
                    level_high_q <= 1'b0; // RQ6
                end
            end
        end
    end

    // core-facing outputs, registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_level <= 4'h0;
            user_irq_blocked <= 1'b0;
            irq_take <= 1'b0;
            math_trap_raise <= 1'b0;
            acc_trap_raise <= 1'b0;
            nesting_off <= 1'b0;
        end else begin
            cpu_level <= level_d; // RQ2
            user_irq_blocked <= level_high_q || (level_low_q == 3'h7); // RQ1 RQ3
            // level 8+ always masks since a three-bit priority never exceeds it
            irq_take <= pending_valid && !level_high_q
                && ({1'b0, pending_priority} > level_d) // RQ20 RQ3
                && !(handler_active && trap_ctl_q[`TC_NESTING_OFF]); // RQ7
            math_trap_raise <= math_any; // RQ15
            acc_trap_raise <= ovf_a_trap || ovf_b_trap || cat_a_trap || cat_b_trap; // RQ10 RQ11
            nesting_off <= trap_ctl_q[`TC_NESTING_OFF]; // RQ7
        end
    end

    // apb: zero wait states, one access phase cycle; unmapped reads zero with error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h00000000;
                if (!pwrite) begin
                    if (addr_hit(paddr, `ADDR_STATUS_WORD)) begin
                        prdata <= {16'h0000, status_word};
                    end else if (addr_hit(paddr, `ADDR_CORE_CONTROL)) begin
                        prdata <= {16'h0000, core_word}; // RQ5
                    end else if (addr_hit(paddr, `ADDR_TRAP_CONTROL)) begin
                        prdata <= {16'h0000, trap_ctl_q}; // RQ19
                    end else if (addr_hit(paddr, `ADDR_LEVEL_VIEW)) begin
                        prdata <= {28'h0000000, level_d}; // RQ2
                    end else begin
                        pslverr <= 1'b1;
                    end
                end else if (!(addr_hit(paddr, `ADDR_STATUS_WORD)
                        || addr_hit(paddr, `ADDR_CORE_CONTROL)
                        || addr_hit(paddr, `ADDR_TRAP_CONTROL)
                        || addr_hit(paddr, `ADDR_LEVEL_VIEW))) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule // cpu_priority_and_trap_status

// *** dv/trap_status_asserts.sv ***
`timescale 1ns/1ps
module trap_status_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire bad_shift_event,
    input wire divide_zero_event,
    input wire level_load,
    input wire [3:0] level_load_value,
    input wire [2:0] pending_priority,
    input wire pending_valid,
    input wire [3:0] cpu_level,
    input wire user_irq_blocked,
    input wire irq_take,
    input wire math_trap_raise,
    input wire acc_trap_raise
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [3:0] ld_q;
    always @(posedge pclk) if (level_load) ld_q <= level_load_value;
    blocked_level_a: assert property (user_irq_blocked == (cpu_level[3] || &cpu_level[2:0]))
        else $error("blocked flag disagrees with level");
    take_high_a: assert property (irq_take |-> !cpu_level[3])
        else $error("interrupt taken at high level");
    take_above_a: assert property (irq_take |-> $past(pending_priority) > cpu_level[2:0])
        else $error("interrupt taken not above level");
    take_pend_a: assert property (irq_take |-> $past(pending_valid))
        else $error("interrupt taken with nothing pending");
    level_load_a: assert property (level_load |-> ##[1:2] cpu_level == ld_q)
        else $error("loaded level not shown");
    shift_math_a: assert property (bad_shift_event || divide_zero_event |=> math_trap_raise)
        else $error("math trap not raised");
    acc_math_a: assert property (acc_trap_raise |-> math_trap_raise)
        else $error("acc trap without math trap");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("apb answer late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    cover property (irq_take);
    cover property (acc_trap_raise);
    cover property (level_load);
endmodule // trap_status_asserts
bind cpu_priority_and_trap_status trap_status_asserts u_chk (.*);

// *** dv/core_events_model.sv ***
`timescale 1ns/1ps
module core_events_model (
    input wire pclk,
    input wire presetn,
    input wire [11:0] req,
    output reg [11:0] ev
);
    // requests become single-cycle pulses, as the core fault logic gives
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) ev <= 12'h000;
        else ev <= req & ~ev;
    end
endmodule // core_events_model

// *** dv/cpu_priority_and_trap_status_tb_top.sv ***
`timescale 1ns/1ps
module cpu_priority_and_trap_status_tb_top;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    reg [11:0] paddr = 0, req = 0;
    reg [31:0] pwdata = 0, rd;
    reg level_load = 0, pending_valid = 0, handler_active = 0;
    reg [3:0] level_load_value = 0;
    reg [2:0] pending_priority = 0;
    reg [15:0] en;
    wire [31:0] prdata;
    wire [11:0] ev;
    wire [3:0] cpu_level;
    wire pready, pslverr, user_irq_blocked, irq_take, math_trap_raise, acc_trap_raise, nesting_off;
    integer seed = 62752, pseed = 62752, err_count = 0, checks_done = 0, i, x, k;
    core_events_model u_core (.pclk(pclk), .presetn(presetn), .req(req), .ev(ev));
    cpu_priority_and_trap_status DUT (.*, .pstrb(4'hF), .acc_a_overflow_event(ev[0]),
        .acc_b_overflow_event(ev[1]), .acc_a_catastrophic_event(ev[2]),
        .acc_b_catastrophic_event(ev[3]), .bad_shift_event(ev[4]), .divide_zero_event(ev[5]),
        .dma_fault_event(ev[6]), .address_trap_event(ev[7]), .stack_trap_event(ev[8]),
        .osc_fail_trap_event(ev[9]), .acc_a_saturate_event(ev[10]), .acc_b_saturate_event(ev[11]));
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) {handler_active, pending_valid, pending_priority} <= 5'($random(pseed));
    task apb(input w, input [11:0] a, input [15:0] d);
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 16'h0000, d};
            @(posedge pclk);
            penable <= 1;
            k = 0;
            do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
            if (k >= 20) err_count++;
            rd = prdata;
            er = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask
    task chk(input [8*6:1] n, input [31:0] e, input [31:0] s);
        begin
            checks_done++;
            if (s !== e) begin err_count++; $display("BAD %0s exp %h got %h", n, e, s); end
        end
    endtask
    task rdc(input [11:0] a, input [31:0] e);
        begin apb(0, a, 0); chk("reg", e, rd); end
    endtask
    // trap word after one event with the given enables; acc flags need their enable
    function [15:0] exp_trap(input integer x, input [15:0] en);
        case (x)
            0: exp_trap = en | (en[10] ? 16'h4010 : 16'h0000);
            1: exp_trap = en | (en[9] ? 16'h2010 : 16'h0000);
            2: exp_trap = en | (en[8] ? 16'h1010 : 16'h0000);
            3: exp_trap = en | (en[8] ? 16'h0810 : 16'h0000);
            4: exp_trap = en | 16'h0090;
            5: exp_trap = en | 16'h0050;
            6: exp_trap = en | 16'h0020;
            7: exp_trap = en | 16'h0008;
            8: exp_trap = en | 16'h0004;
            9: exp_trap = en | 16'h0002;
            default: exp_trap = en;
        endcase
    endfunction
    task give_verdict;
        begin
            $display("errors %0d checks %0d", err_count, checks_done);
            if (err_count == 0 && checks_done > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin repeat (20000) @(posedge pclk); err_count++; give_verdict; end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 12; i += 4) rdc(i, 0);
        apb(0, 12'h010, 0); chk("unmap", 0, rd);
        chk("slverr", 1, er);
        apb(1, 12'h008, 16'hFFFF); rdc(12'h008, 32'h8700);
        apb(1, 12'h008, 0);
        for (i = 0; i < 36; i++) begin
            x = i < 12 ? i : {$random(seed)} % 12;
            en = i < 12 ? 16'h0700 : $random(seed) & 16'h0700;
            apb(1, 12'h008, en);
            @(posedge pclk) req <= 12'h001 << x;
            @(posedge pclk) req <= 0;
            rdc(12'h008, exp_trap(x, en));
            rdc(12'h000, x == 10 ? 16'h2400 : x == 11 ? 16'h1400 : 0);
            rdc(12'h008, exp_trap(x, en));
            apb(1, 12'h008, en);
            apb(1, 12'h000, 0);
            rdc(12'h008, en);
        end
        apb(1, 12'h000, 16'h00E0); rdc(12'h000, 16'h00E0); rdc(12'h00C, 7);
        chk("blk7", 1, user_irq_blocked);
        apb(1, 12'h004, 16'h0008); rdc(12'h004, 0);
        @(posedge pclk) {level_load, level_load_value} <= 5'h1A;
        @(posedge pclk) level_load <= 0;
        rdc(12'h004, 8); rdc(12'h00C, 4'hA); rdc(12'h000, 16'h0040);
        chk("blkhi", 1, user_irq_blocked);
        chk("lvlhi", 4'hA, cpu_level);
        apb(1, 12'h004, 0); rdc(12'h00C, 2);
        chk("blklo", 0, user_irq_blocked);
        chk("lvllo", 2, cpu_level);
        apb(1, 12'h008, 16'h8000); apb(1, 12'h000, 16'h00A0); rdc(12'h000, 16'h0040);
        chk("nest", 1, nesting_off);
        apb(1, 12'h008, 0);
        give_verdict;
    end
endmodule // cpu_priority_and_trap_status_tb_top
